// file: design/pvc_pkg.sv
// package: register map, field positions, reset values and carrier types for the vendor config bank
// Functional notes
// - config bit 5 connects the A-device idle VBUS load; resets to 1.
// - config bit 4 flags external VBUS series resistor; shifts comparator thresholds; resets 1.
// - config bit 3 picks open-source high or open-drain low switch drive; resets 0.
// - config bit 2 selects push-pull switch drive and overrides bit 3; resets 0.
// - config bits 1 and 0 read debounced D+ and D- comparators; read-only, reset 0.
// - comparators enable automatically in four D+ source or pull-up cases.
// - event bit 6 enables resume watchdog, started on resume K; resets to 1.
// - event bit 5 makes every ID-float transition send a receive command.
// - event bit 4 makes accessory resistor changes send receive command with alt_int.
// - event bit 4 forces the ID pull-up on regardless of its own control bit.
// - event bit 3 raises a notification when the session watchdog expires.
// - event bits 2 and 1 enable VBUS monitor rising and falling notifications.
// - event bit 0 reports each debounced battery comparator transition by receive command.
// - accessory bit 7 with RID_B reports session and VBUS valid as 0, disables SRP resistors.
// - accessory bit 6 with RID_A reports ID as ground and deasserts the switch output.
// - accessory bit 6 clear leaves receive command and switch output untouched by RID_A.
// - accessory bit 5 enables the frame clock output at microframe rate; resets 0.
// - clear alias: writing 1 clears base bit, 0 does nothing, reads return base.
package pvc_pkg;
  localparam logic [7:0] ADDR_CFG = 8'h88;
  localparam logic [7:0] ADDR_CFG_SET = 8'h89;
  localparam logic [7:0] ADDR_CFG_CLR = 8'h8A;
  localparam logic [7:0] ADDR_EVT = 8'h8B;
  localparam logic [7:0] ADDR_EVT_SET = 8'h8C;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h8D;
  localparam logic [7:0] ADDR_ACC = 8'h8E;
  localparam logic [7:0] ADDR_ACC_SET = 8'h8F;
  localparam logic [7:0] ADDR_ACC_CLR = 8'h90;

  localparam int CFG_ACA_DET = 6;
  localparam int CFG_A_LOAD = 5;
  localparam int CFG_SERIES = 4;
  localparam int CFG_POL = 3;
  localparam int CFG_PP = 2;
  localparam int CFG_DP = 1;
  localparam int CFG_DM = 0;
  localparam int EVT_RESUME = 6;
  localparam int EVT_IDFLT = 5;
  localparam int EVT_ACA = 4;
  localparam int EVT_SESS = 3;
  localparam int EVT_VRISE = 2;
  localparam int EVT_VFALL = 1;
  localparam int EVT_BATT = 0;
  localparam int ACC_B = 7;
  localparam int ACC_A = 6;
  localparam int ACC_SOF = 5;

  // writable masks keep reserved and read-only bits out of the stores
  localparam logic [7:0] CFG_WMASK = 8'h7C;
  localparam logic [7:0] EVT_WMASK = 8'h7F;
  localparam logic [7:0] ACC_WMASK = 8'hE0;
  localparam logic [7:0] CFG_RESET = 8'h70;
  localparam logic [7:0] EVT_RESET = 8'h40;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // frame clock time base: microframe rate against the core clock
  localparam int CLK_HZ = 20000000;
  localparam int FRAME_HZ = 8000;
  localparam int FRAME_HALF = CLK_HZ / FRAME_HZ / 2;

  localparam logic [1:0] ACA_NONE = 2'h0;
  localparam logic [1:0] ACA_A = 2'h1;
  localparam logic [1:0] ACA_B = 2'h2;
  localparam logic [1:0] ACA_C = 2'h3;

  // receive command request towards the link framer
  typedef struct packed {
    logic idFloat;
    logic aca;
    logic sessWdog;
    logic vbusRise;
    logic vbusFall;
    logic battery;
  } pvc_event_t;

  // analogue-side levels sampled every clock, the D+ and D- comparators only in the automatic enable cases
  typedef struct packed {
    logic dplusComp;
    logic dminusComp;
    logic detFsmSrcOn;
    logic manualCtrl;
    logic dplusVoltSrc;
    logic dplusCurrSrc;
    logic dplusWeakPullup;
    logic idFloat;
    logic [1:0] acaStatus;
    logic sessWdogExpired;
    logic vbusMonitor;
    logic batteryLevel;
    logic resumeK;
    logic vbusValid;
    logic sessValid;
    logic idGround;
    logic idPullupCtrl;
    logic powerSwitchReq;
    logic srpPullupReq;
    logic srpPulldownReq;
  } pvc_analog_t;
endpackage

// file: design/pvc_frame_clock.sv
// frame clock generator: toggles the start-of-frame output every half microframe (HALF_PERIOD cycles), one period per microframe, while enabled
`timescale 1ns/1ps
module pvc_frame_clock
  import pvc_pkg::*;
#(
  parameter int HALF_PERIOD = 1250
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  output logic frameClock
);
  logic [15:0] count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 16'h0000;
      frameClock <= 1'b0;
    end else if (!enable) begin
      // held low so the pin is quiet when the feature is off
      count <= 16'h0000;
      frameClock <= 1'b0;
    end else if (count == 16'(HALF_PERIOD - 1)) begin
      count <= 16'h0000;
      frameClock <= ~frameClock;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule

// file: design/pvc_vendor_regs.sv
// vendor configuration and event enable register bank with set and clear aliases
`timescale 1ns/1ps
module pvc_vendor_regs
  import pvc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regHit,
  input wire pvc_analog_t analogIn,
  output pvc_event_t eventReq,
  output logic altInt,
  output logic resumeWdogStart,
  output logic aIdleVbusLoadEn,
  output logic vbusSeriesResPresent,
  output logic serxCompEn,
  output logic powerSwitchOut,
  output logic powerSwitchOe,
  output logic idPullupEn,
  output logic srpPullup,
  output logic srpPulldown,
  output logic rxVbusValid,
  output logic rxSessValid,
  output logic rxIdGround,
  output logic frameClock
);
  logic [7:0] cfgStore;
  logic [7:0] evtStore;
  logic [7:0] accStore;
  logic [7:0] next_cfg;
  logic [7:0] next_evt;
  logic [7:0] next_acc;
  logic dplusSample;
  logic dminusSample;
  logic idFloatPrev;
  logic [1:0] acaPrev;
  logic sessPrev;
  logic vbusPrev;
  logic battPrev;
  logic resumePrev;
  logic compAuto;
  logic bBlock;
  logic aForce;
  logic swAsserted;
  // change detectors, gated until the history is valid
  logic primed;
  logic idFloatEdge;
  logic acaChange;
  logic sessRise;
  logic vbusRiseEdge;
  logic vbusFallEdge;
  logic battEdge;
  logic resumeRise;

  // writes: base stores, set alias ORs, clear alias ANDs out; read-only bits never stored
  function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic [7:0] mask,
                                             input logic [7:0] base, input logic [7:0] setA,
                                             input logic [7:0] clrA, input logic [7:0] addr,
                                             input logic [7:0] data, input logic hasClr);
    logic [7:0] res;
    res = cur;
    if (addr == base) begin
      res = data & mask;
    end else if (addr == setA) begin
      res = cur | (data & mask);
    end else if (hasClr && addr == clrA) begin
      res = cur & ~(data & mask);
    end
    return res;
  endfunction

  always_comb begin
    next_cfg = cfgStore;
    next_evt = evtStore;
    next_acc = accStore;
    if (regWrite) begin
      next_cfg = apply_write(cfgStore, CFG_WMASK, ADDR_CFG, ADDR_CFG_SET, ADDR_CFG_CLR,
                             regAddr, regWdata, 1'b1);
      next_evt = apply_write(evtStore, EVT_WMASK, ADDR_EVT, ADDR_EVT_SET, ADDR_EVT_CLR,
                             regAddr, regWdata, 1'b1);
      next_acc = apply_write(accStore, ACC_WMASK, ADDR_ACC, ADDR_ACC_SET, ADDR_ACC_CLR,
                             regAddr, regWdata, 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgStore <= CFG_RESET;
    end else begin
      cfgStore <= next_cfg;
    end
  end

  // one store per register; the aliases only steer which one updates
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtStore <= EVT_RESET;
    end else begin
      evtStore <= next_evt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accStore <= ACC_RESET;
    end else begin
      accStore <= next_acc;
    end
  end

  // comparator capture only while one of the automatic enable cases holds
  assign compAuto = analogIn.detFsmSrcOn || (analogIn.manualCtrl && analogIn.dplusVoltSrc) ||
                    (analogIn.manualCtrl && analogIn.dplusCurrSrc) || analogIn.dplusWeakPullup;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dplusSample <= 1'b0;
      dminusSample <= 1'b0;
    end else if (compAuto) begin
      // outside the auto cases the last value holds; the link must not trust it then
      dplusSample <= analogIn.dplusComp;
      dminusSample <= analogIn.dminusComp;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serxCompEn <= 1'b0;
    end else begin
      serxCompEn <= compAuto;
    end
  end

  // readback mixes stored fields with live status; alias addresses return the base register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
      regHit <= 1'b0;
    end else begin
      regHit <= 1'b0;
      if (regRead) begin
        regHit <= 1'b1;
        unique case (regAddr)
          ADDR_CFG, ADDR_CFG_SET, ADDR_CFG_CLR: begin
            regRdata <= {cfgStore[7:2], dplusSample, dminusSample};
          end
          ADDR_EVT, ADDR_EVT_SET, ADDR_EVT_CLR: begin
            regRdata <= evtStore;
          end
          ADDR_ACC, ADDR_ACC_SET, ADDR_ACC_CLR: begin
            regRdata <= accStore;
          end
          default: begin
            regRdata <= 8'h00;
            regHit <= 1'b0;
          end
        endcase
      end
    end
  end

  // transition detection on the debounced levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idFloatPrev <= 1'b0;
      acaPrev <= ACA_NONE;
      sessPrev <= 1'b0;
      vbusPrev <= 1'b0;
      battPrev <= 1'b0;
      resumePrev <= 1'b0;
    end else begin
      idFloatPrev <= analogIn.idFloat;
      acaPrev <= analogIn.acaStatus;
      sessPrev <= analogIn.sessWdogExpired;
      vbusPrev <= analogIn.vbusMonitor;
      battPrev <= analogIn.batteryLevel;
      resumePrev <= analogIn.resumeK;
    end
  end

  // the detectors start from zero after reset; a pin that idles high would look like an edge,
  // so nothing is reported until one full cycle of history exists
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  assign idFloatEdge = primed && (analogIn.idFloat != idFloatPrev);
  assign acaChange = primed && (analogIn.acaStatus != acaPrev);
  assign sessRise = primed && analogIn.sessWdogExpired && !sessPrev;
  assign vbusRiseEdge = primed && analogIn.vbusMonitor && !vbusPrev;
  assign vbusFallEdge = primed && !analogIn.vbusMonitor && vbusPrev;
  assign battEdge = primed && (analogIn.batteryLevel != battPrev);
  assign resumeRise = primed && analogIn.resumeK && !resumePrev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eventReq <= '0;
    end else begin
      eventReq.idFloat <= evtStore[EVT_IDFLT] && idFloatEdge;
      eventReq.aca <= evtStore[EVT_ACA] && acaChange;
      eventReq.sessWdog <= evtStore[EVT_SESS] && sessRise;
      eventReq.vbusRise <= evtStore[EVT_VRISE] && vbusRiseEdge;
      eventReq.vbusFall <= evtStore[EVT_VFALL] && vbusFallEdge;
      eventReq.battery <= evtStore[EVT_BATT] && battEdge;
    end
  end

  // alt_int rides on the same receive command as the accessory change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      altInt <= 1'b0;
    end else begin
      altInt <= evtStore[EVT_ACA] && acaChange;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resumeWdogStart <= 1'b0;
    end else begin
      resumeWdogStart <= evtStore[EVT_RESUME] && resumeRise;
    end
  end

  // accessory overrides on reported levels and the switch
  assign bBlock = accStore[ACC_B] && (analogIn.acaStatus == ACA_B);
  assign aForce = accStore[ACC_A] && (analogIn.acaStatus == ACA_A);
  assign swAsserted = analogIn.powerSwitchReq && !aForce;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxVbusValid <= 1'b0;
      rxSessValid <= 1'b0;
    end else begin
      rxVbusValid <= analogIn.vbusValid && !bBlock;
      rxSessValid <= analogIn.sessValid && !bBlock;
    end
  end

  // the stored charge commands are untouched; only their effect on the resistors is masked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srpPullup <= 1'b0;
      srpPulldown <= 1'b0;
    end else begin
      srpPullup <= analogIn.srpPullupReq && !bBlock;
      srpPulldown <= analogIn.srpPulldownReq && !bBlock;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxIdGround <= 1'b0;
      idPullupEn <= 1'b0;
    end else begin
      rxIdGround <= analogIn.idGround || aForce;
      idPullupEn <= analogIn.idPullupCtrl || evtStore[EVT_ACA];
    end
  end

  // analogue trims follow the stored bits; their reset values match the register reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aIdleVbusLoadEn <= 1'b1;
      vbusSeriesResPresent <= 1'b1;
    end else begin
      aIdleVbusLoadEn <= cfgStore[CFG_A_LOAD];
      vbusSeriesResPresent <= cfgStore[CFG_SERIES];
    end
  end

  // pad style: push-pull drives both levels, open-source drives high only, open-drain low only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerSwitchOut <= 1'b0;
      powerSwitchOe <= 1'b0;
    end else if (cfgStore[CFG_PP]) begin
      powerSwitchOut <= swAsserted;
      powerSwitchOe <= 1'b1;
    end else if (cfgStore[CFG_POL]) begin
      powerSwitchOut <= 1'b0;
      powerSwitchOe <= swAsserted;
    end else begin
      powerSwitchOut <= 1'b1;
      powerSwitchOe <= swAsserted;
    end
  end

  pvc_frame_clock #(
    .HALF_PERIOD(FRAME_HALF)
  ) u_frame_clock (
    .clk(clk),
    .rstn(rstn),
    .enable(accStore[ACC_SOF]),
    .frameClock(frameClock)
  );
endmodule

// file: sim/pvc_vendor_regs_sva.sv
// checker: port-level assertions for the vendor register bank
`timescale 1ns/1ps
module pvc_vendor_regs_sva
  import pvc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic regHit,
  input wire pvc_analog_t analogIn,
  input wire pvc_event_t eventReq,
  input wire logic altInt,
  input wire logic resumeWdogStart,
  input wire logic serxCompEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic autoEn;
  assign autoEn = analogIn.detFsmSrcOn || analogIn.dplusWeakPullup ||
    (analogIn.manualCtrl && (analogIn.dplusVoltSrc || analogIn.dplusCurrSrc));
  a_comp_auto_en: assert property (1'b1 |=> serxCompEn == $past(autoEn))
    else $error("comparator enable does not follow the source state");
  a_alt_with_aca: assert property (altInt == eventReq.aca)
    else $error("alt_int and accessory event disagree");
  a_unmapped_read: assert property (regRead && !(regAddr inside {[ADDR_CFG:ADDR_ACC_CLR]})
    |=> !regHit && regRdata == 8'h00) else $error("unmapped read answered");
  a_batt_cause: assert property (eventReq.battery |->
    $past(analogIn.batteryLevel) != $past(analogIn.batteryLevel, 2)) else $error("battery event without change");
  a_vbus_rise: assert property (eventReq.vbusRise |->
    $past(analogIn.vbusMonitor) && !$past(analogIn.vbusMonitor, 2)) else $error("rise event without rise");
  a_vbus_fall: assert property (eventReq.vbusFall |->
    !$past(analogIn.vbusMonitor) && $past(analogIn.vbusMonitor, 2)) else $error("fall event without fall");
  a_idflt_cause: assert property (eventReq.idFloat |->
    $past(analogIn.idFloat) != $past(analogIn.idFloat, 2)) else $error("id float event without change");
  a_aca_cause: assert property (eventReq.aca |->
    $past(analogIn.acaStatus) != $past(analogIn.acaStatus, 2)) else $error("accessory event without change");
  a_resume_start: assert property (resumeWdogStart |->
    $past(analogIn.resumeK) && !$past(analogIn.resumeK, 2)) else $error("watchdog start without resume");
  cover property (eventReq.aca);
  cover property (resumeWdogStart);
  cover property (regRead ##1 regHit);
endmodule

bind pvc_vendor_regs pvc_vendor_regs_sva pvc_vendor_regs_sva_i (.clk(clk), .rstn(rstn), .regRead(regRead),
  .regAddr(regAddr), .regRdata(regRdata), .regHit(regHit), .analogIn(analogIn), .eventReq(eventReq),
  .altInt(altInt), .resumeWdogStart(resumeWdogStart), .serxCompEn(serxCompEn));

// file: sim/pvc_link_model.sv
// link-side model: counts receive commands raised towards the link
`timescale 1ns/1ps
module pvc_link_model
  import pvc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire pvc_event_t eventReq,
  input wire logic altInt,
  output logic [7:0] rxCount,
  output logic [7:0] altCount
);
  // line levels are taken from receive commands only, never from comparator status bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxCount <= 8'h00;
      altCount <= 8'h00;
    end else begin
      rxCount <= rxCount + 8'(|eventReq);
      altCount <= altCount + 8'(altInt);
    end
  end
endmodule

// file: sim/tb.sv
// testbench: register, event, accessory and frame clock scenarios
`timescale 1ns/1ps
module tb
  import pvc_pkg::*;
;
  logic clk, rstn, regWrite, regRead, regHit, altInt, resumeWdogStart, aIdleVbusLoadEn, vbusSeriesResPresent;
  logic serxCompEn, powerSwitchOut, powerSwitchOe, idPullupEn, srpPullup, srpPulldown, rxVbusValid;
  logic rxSessValid, rxIdGround, frameClock;
  logic [7:0] regAddr, regWdata, regRdata, rxCount, altCount, r;
  logic [1:0] last;
  logic [6:0] evExp [8] = '{7'h01, 7'h04, 7'h02, 7'h08, 7'h00, 7'h20, 7'h10, 7'h40};
  logic [7:0] q[$];
  pvc_analog_t ana;
  pvc_event_t eventReq;
  int miscompares, nTests, cyc, k;

  always #25 clk = ~clk;

  pvc_vendor_regs pvc_vendor_regs_i (.clk, .rstn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regHit,
    .analogIn(ana), .eventReq, .altInt, .resumeWdogStart, .aIdleVbusLoadEn, .vbusSeriesResPresent, .serxCompEn,
    .powerSwitchOut, .powerSwitchOe, .idPullupEn, .srpPullup, .srpPulldown, .rxVbusValid, .rxSessValid,
    .rxIdGround, .frameClock);
  pvc_link_model pvc_link_model_i (.clk, .rstn, .eventReq, .altInt, .rxCount, .altCount);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic endSim;
    chk(16'(q.size()), 16'h0000);
    $display("comparisons=%0d mismatches=%0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // levels lag one cycle behind their cause, so allow two before looking
  task automatic sync;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    if (a inside {[ADDR_CFG:ADDR_ACC_CLR]}) q.push_back(e);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regHit, a inside {[ADDR_CFG:ADDR_ACC_CLR]});
  endtask
  task automatic evt(input int s);
    @(posedge clk);
    case (s)
      0: ana.batteryLevel <= ~ana.batteryLevel;
      1, 2: ana.vbusMonitor <= ~ana.vbusMonitor;
      3, 4: ana.sessWdogExpired <= ~ana.sessWdogExpired;
      5: ana.idFloat <= ~ana.idFloat;
      6: ana.acaStatus <= ana.acaStatus + 2'h1;
      default: ana.resumeK <= ~ana.resumeK;
    endcase
    @(posedge clk);
    @(negedge clk);
  endtask

  always @(negedge clk) begin
    if (regHit === 1'b1) begin
      if (q.size() == 0) chk(regHit, 1'b0);
      else chk(regRdata, q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      endSim;
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    ana = '0;
    last = 2'h0;
    void'($urandom(48));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 9; k++) rd(ADDR_CFG + 8'(k), k < 3 ? 8'h70 : (k < 6 ? 8'h40 : 8'h00));
    rd(8'h87, 8'h00);
    rd(8'h91, 8'h00);
    chk({aIdleVbusLoadEn, vbusSeriesResPresent}, 2'h3);
    for (k = 0; k < 5; k++) begin
      r = 8'($urandom);
      @(posedge clk);
      ana.detFsmSrcOn <= (k == 0);
      ana.manualCtrl <= (k == 1 || k == 2);
      ana.dplusVoltSrc <= (k == 1 || k == 4);
      ana.dplusCurrSrc <= (k == 2);
      ana.dplusWeakPullup <= (k == 3);
      ana.dplusComp <= r[1];
      ana.dminusComp <= r[0];
      if (k < 4) last = r[1:0];
      sync;
      chk(serxCompEn, k < 4);
      rd(ADDR_CFG_SET, 8'h70 | {6'h00, last});
    end
    wr(ADDR_CFG_CLR, 8'h33);
    sync;
    chk({aIdleVbusLoadEn, vbusSeriesResPresent}, 2'h0);
    rd(ADDR_CFG, 8'h40 | {6'h00, last});
    for (k = 0; k < 4; k++) begin
      r = 8'($urandom);
      wr(ADDR_CFG_CLR, 8'h0C);
      wr(ADDR_CFG_SET, 8'(k << 2));
      ana.powerSwitchReq <= r[0];
      sync;
      chk({powerSwitchOut, powerSwitchOe}, k[0] ? {r[0], 1'b1} : {~k[1], r[0]});
    end
    for (int p = 0; p < 2; p++) begin
      wr(p ? ADDR_EVT_CLR : ADDR_EVT_SET, p ? 8'h7F : 8'h3F);
      sync;
      chk(idPullupEn, p == 0);
      for (k = 0; k < 8; k++) begin
        evt(k);
        chk({resumeWdogStart, eventReq}, p ? 7'h00 : evExp[k]);
      end
    end
    chk(rxCount, 8'h06);
    chk(altCount, 8'h01);
    wr(ADDR_CFG_CLR, 8'h0C);
    ana.powerSwitchReq <= 1'b1;
    ana.acaStatus <= ACA_A;
    ana.vbusValid <= 1'b1;
    ana.sessValid <= 1'b1;
    ana.srpPullupReq <= 1'b1;
    for (k = 0; k < 2; k++) begin
      if (k == 1) wr(ADDR_ACC_SET, 8'h40);
      sync;
      chk({rxIdGround, powerSwitchOe}, k ? 2'h2 : 2'h1);
    end
    @(posedge clk);
    ana.acaStatus <= ACA_B;
    ana.srpPulldownReq <= 1'b1;
    for (k = 0; k < 2; k++) begin
      if (k == 1) wr(ADDR_ACC_SET, 8'h80);
      sync;
      chk({rxVbusValid, rxSessValid, srpPullup, srpPulldown}, k ? 4'h0 : 4'hF);
    end
    r = 8'($urandom);
    wr(ADDR_EVT, r);
    rd(ADDR_EVT_CLR, r & 8'h7F);
    wr(ADDR_ACC, r & 8'hDF);
    rd(ADDR_ACC_SET, r & 8'hC0);
    wr(ADDR_ACC_SET, 8'h20);
    k = 0;
    while (frameClock !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (frameClock === 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'h04E2);
    wr(ADDR_ACC_CLR, 8'h20);
    sync;
    chk(frameClock, 1'b0);
    endSim;
  end
endmodule
